// File: src/color_space_matrix_converter.sv
/*
  Pipelined converter among RGB, offset YUV and scaled CCIR pixels,
  10 bits per component, with bypass for matching spaces.
  Assumes source and sink logic on the same clock, valid/ready streams.
*/
// What this block does
// - RGB components are unsigned 10-bit, 0 to 1023.
// - RGB destination results clamp to 0..1023.
// - Clamp input is 12-bit signed, may wrap.
// - RGB to YUV matrix, chroma offset 512.
// - YUV spans 0..1023, black 512,0,512.
// - CCIR uses scaled matrix, offsets 512,64,512.
// - CCIR outputs clamp to 4..1019.
// - Every stage keeps at least 10 bits.
// - Inputs become 12-bit signed, offsets removed.
// - 15-bit signed coefficients, 26-bit accumulators.
// - Upper 16 accumulator bits feed offset-and-clamp stage.
// - RGB-CCIR-RGB round trip within four codes.
// - RGB-YUV-RGB round trip within three codes.
// - Coefficients rounded slightly high, not low.
// - Matching spaces bypass, bit-exact.
// - Each pixel carries its own source space.
// - Destination space selects; matching streams unconverted.
// - Unrepresentable colours saturate per component.
// - CCIR to YUV saturates superblack and superwhite.
// - RGB into CCIR never needs clamping; RGB into YUV chroma can reach 1024 and is clamped.
`timescale 1ns/1ps
`default_nettype none

module color_space_matrix_converter (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Pixel in
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [29:0] in_pixel,
  input wire logic [1:0] in_space,
  // Destination space
  input wire logic [1:0] dst_space,
  // Pixel out
  output logic out_valid,
  input wire logic out_ready,
  output logic [29:0] out_pixel,
  output logic [1:0] out_space
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] comp(logic [29:0] p, int k);
    comp = p[(2-k)*10 +: 10];
  endfunction : comp

  function automatic logic [9:0] space_off(logic [1:0] sp, int k);
    if (k == 1) begin
      space_off = (sp == csc_pkg::SPACE_CCIR) ? csc_pkg::CCIR_LUMA_OFF
                                                : csc_pkg::ZERO_OFF;
    end else begin
      space_off = (sp == csc_pkg::SPACE_RGB) ? csc_pkg::ZERO_OFF
                                               : csc_pkg::CHROMA_OFF;
    end
  endfunction : space_off

  function automatic logic [134:0] matrix(logic [1:0] s, logic [1:0] d);
    matrix = csc_pkg::M_NONE;
    unique case ({s, d})
      {csc_pkg::SPACE_RGB, csc_pkg::SPACE_YUV}: matrix = csc_pkg::M_RGB_YUV;
      {csc_pkg::SPACE_RGB, csc_pkg::SPACE_CCIR}: matrix = csc_pkg::M_RGB_CCIR;
      {csc_pkg::SPACE_YUV, csc_pkg::SPACE_RGB}: matrix = csc_pkg::M_YUV_RGB;
      {csc_pkg::SPACE_CCIR, csc_pkg::SPACE_RGB}: matrix = csc_pkg::M_CCIR_RGB;
      {csc_pkg::SPACE_YUV, csc_pkg::SPACE_CCIR}: matrix = csc_pkg::M_YUV_CCIR;
      {csc_pkg::SPACE_CCIR, csc_pkg::SPACE_YUV}: matrix = csc_pkg::M_CCIR_YUV;
      default: matrix = csc_pkg::M_NONE;
    endcase
  endfunction : matrix

  function automatic logic signed [14:0] coef(logic [134:0] m, int k);
    coef = $signed(m[(8-k)*15 +: 15]);
  endfunction : coef

  function automatic logic legal(logic [1:0] sp);
    legal = sp != csc_pkg::SPACE_RSVD;
  endfunction : legal

  // Saturate a 12-bit signed result into the destination range
  function automatic logic [9:0] clamp(logic signed [11:0] v,
                                       logic [1:0] d);
    logic signed [11:0] lo;
    logic signed [11:0] hi;
    lo = $signed({2'b00, csc_pkg::FULL_MIN});
    hi = $signed({2'b00, csc_pkg::FULL_MAX});
    if (d == csc_pkg::SPACE_CCIR) begin
      lo = $signed({2'b00, csc_pkg::CCIR_MIN});
      hi = $signed({2'b00, csc_pkg::CCIR_MAX});
    end
    if (v < lo) begin
      clamp = lo[9:0];
    end else if (v > hi) begin
      clamp = hi[9:0];
    end else begin
      clamp = v[9:0];
    end
  endfunction : clamp

  // ----------------------------------------------------------------
  // Pipeline registers
  // ----------------------------------------------------------------
  logic en;
  logic s1_v_r, s2_v_r, s3_v_r;
  logic s1_conv_r, s2_conv_r, s3_conv_r;
  logic [1:0] s1_src_r, s2_src_r, s3_src_r;
  logic [1:0] s1_dst_r, s2_dst_r, s3_dst_r;
  logic [29:0] s1_raw_r, s2_raw_r, s3_raw_r;
  logic [29:0] s3_pix_r;
  logic signed [11:0] s1_x_r [3];
  logic signed [25:0] s2_acc_r [3];
  logic signed [25:0] acc_nxt [3];
  logic [29:0] pix_nxt;
  logic [134:0] mat;

  // Whole pipeline stalls while the output buffer is full
  assign en = in_ready;

  // ----------------------------------------------------------------
  // Stage 1: remove offsets, widen to 12-bit signed
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_v_r <= 1'b0;
      s1_conv_r <= 1'b0;
      s1_src_r <= csc_pkg::SPACE_RGB;
      s1_dst_r <= csc_pkg::SPACE_RGB;
      s1_raw_r <= csc_pkg::PIX_RST;
      for (int k = 0; k < 3; k++) begin
        s1_x_r[k] <= '0;
      end
    end else if (en) begin
      s1_v_r <= in_valid;
      s1_src_r <= in_space;
      s1_dst_r <= dst_space;
      s1_raw_r <= in_pixel;
      s1_conv_r <= (in_space != dst_space) && legal(in_space)
                   && legal(dst_space);
      for (int k = 0; k < 3; k++) begin
        s1_x_r[k] <= $signed({2'b00, comp(in_pixel, k)})
                     - $signed({2'b00, space_off(in_space, k)});
      end
    end
  end

  // ----------------------------------------------------------------
  // Stage 2: 3x3 multiply, 26-bit accumulate
  // ----------------------------------------------------------------
  assign mat = matrix(s1_src_r, s1_dst_r);

  always_comb begin
    logic signed [26:0] prod;
    prod = '0;
    for (int r = 0; r < 3; r++) begin
      acc_nxt[r] = '0;
      for (int c = 0; c < 3; c++) begin
        prod = s1_x_r[c] * coef(mat, r * 3 + c);
        acc_nxt[r] = acc_nxt[r] + 26'(prod);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s2_v_r <= 1'b0;
      s2_conv_r <= 1'b0;
      s2_src_r <= csc_pkg::SPACE_RGB;
      s2_dst_r <= csc_pkg::SPACE_RGB;
      s2_raw_r <= csc_pkg::PIX_RST;
      for (int k = 0; k < 3; k++) begin
        s2_acc_r[k] <= '0;
      end
    end else if (en) begin
      s2_v_r <= s1_v_r;
      s2_conv_r <= s1_conv_r;
      s2_src_r <= s1_src_r;
      s2_dst_r <= s1_dst_r;
      s2_raw_r <= s1_raw_r;
      for (int k = 0; k < 3; k++) begin
        s2_acc_r[k] <= acc_nxt[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Stage 3: top 16 bits, round, add offset, clamp or bypass
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [15:0] top;
    logic signed [11:0] v;
    top = '0;
    v = '0;
    pix_nxt = s2_raw_r;
    if (s2_conv_r) begin
      for (int k = 0; k < 3; k++) begin
        top = s2_acc_r[k][25:10] + csc_pkg::RND_HALF;
        v = top[13:2]
            + $signed({2'b00, space_off(s2_dst_r, k)});
        pix_nxt[(2-k)*10 +: 10] = clamp(v, s2_dst_r);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s3_v_r <= 1'b0;
      s3_conv_r <= 1'b0;
      s3_src_r <= csc_pkg::SPACE_RGB;
      s3_dst_r <= csc_pkg::SPACE_RGB;
      s3_raw_r <= csc_pkg::PIX_RST;
      s3_pix_r <= csc_pkg::PIX_RST;
    end else if (en) begin
      s3_v_r <= s2_v_r;
      s3_conv_r <= s2_conv_r;
      s3_src_r <= s2_src_r;
      s3_dst_r <= s2_dst_r;
      s3_raw_r <= s2_raw_r;
      s3_pix_r <= pix_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  pixel_skid_buffer #(
    .W(csc_pkg::BUF_W),
    .DEPTH(csc_pkg::BUF_DEPTH)
  ) u_out_buf (
    .clock(clock),
    .nrst(nrst),
    .in_valid(s3_v_r),
    .in_ready(in_ready),
    .in_data({s3_dst_r, s3_pix_r}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_space, out_pixel})
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rgb_range;
    @(posedge clock) disable iff (!nrst)
    (en && s2_v_r && s2_conv_r && s2_dst_r == csc_pkg::SPACE_RGB
     && s2_acc_r[0][25])
      |=> (s3_pix_r[29:20] == csc_pkg::FULL_MIN);
  endproperty
  a_rgb_range: assert property (p_rgb_range)
    else $error("negative red result not clamped to zero");

  property p_ccir_range;
    @(posedge clock) disable iff (!nrst)
    (s3_v_r && s3_conv_r && s3_dst_r == csc_pkg::SPACE_CCIR)
      |-> (s3_pix_r[19:10] >= csc_pkg::CCIR_MIN
           && s3_pix_r[19:10] <= csc_pkg::CCIR_MAX
           && s3_pix_r[9:0] >= csc_pkg::CCIR_MIN
           && s3_pix_r[29:20] <= csc_pkg::CCIR_MAX);
  endproperty
  a_ccir_range: assert property (p_ccir_range)
    else $error("ccir component outside 4..1019");

  property p_bypass;
    @(posedge clock) disable iff (!nrst)
    (en && s2_v_r && !s2_conv_r) |=> (s3_pix_r == $past(s2_raw_r));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypassed pixel altered");

  property p_latency;
    @(posedge clock) disable iff (!nrst)
    (in_valid && en) ##1 en [*2] |=> s3_v_r;
  endproperty
  a_latency: assert property (p_latency)
    else $error("pixel not at stage three after three advances");

  property p_offset_removed;
    @(posedge clock) disable iff (!nrst)
    (en && in_valid && in_space == csc_pkg::SPACE_CCIR)
      |=> (s1_x_r[1] == $signed({2'b00, $past(in_pixel[19:10])}) - 12'sd64);
  endproperty
  a_offset_removed: assert property (p_offset_removed)
    else $error("ccir luma offset not removed");

  property p_superblack;
    @(posedge clock) disable iff (!nrst)
    (s3_v_r && s3_conv_r && s3_src_r == csc_pkg::SPACE_CCIR
     && s3_dst_r == csc_pkg::SPACE_YUV && s3_raw_r[19:10] < 10'h040)
      |-> (s3_pix_r[19:10] == 10'h000);
  endproperty
  a_superblack: assert property (p_superblack)
    else $error("superblack luma not clipped to black");

  property p_yuv_black;
    @(posedge clock) disable iff (!nrst)
    (s3_v_r && s3_conv_r && s3_src_r == csc_pkg::SPACE_RGB
     && s3_dst_r == csc_pkg::SPACE_YUV && s3_raw_r == 30'h0)
      |-> (s3_pix_r == {csc_pkg::CHROMA_OFF, 10'h000, csc_pkg::CHROMA_OFF});
  endproperty
  a_yuv_black: assert property (p_yuv_black)
    else $error("rgb black not 512,0,512 in yuv");

  property p_stall_hold;
    @(posedge clock) disable iff (!nrst)
    (!en && s3_v_r) |=> (s3_v_r && $stable(s3_pix_r));
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("stage three word lost during stall");

endmodule : color_space_matrix_converter

`default_nettype wire

// File: src/csc_pkg.sv
/*
  Shared constants for the colour-space matrix converter: widths, space
  codes, offsets, clamp limits and the fixed-point conversion matrices.
  Assumes nothing of its surroundings.
*/
package csc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int COMP_W = 10;
  localparam int PIX_W = 30;
  localparam int X_W = 12;
  localparam int COEF_W = 15;
  localparam int ACC_W = 26;
  localparam int RES_W = 16;
  localparam int MAT_W = 135;
  localparam int SPACE_W = 2;
  localparam int BUF_W = 32;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------
  // Colour spaces
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPACE_RGB = 2'b00,
    SPACE_YUV = 2'b01,
    SPACE_CCIR = 2'b10,
    SPACE_RSVD = 2'b11
  } space_e;

  // ----------------------------------------------------------------
  // Offsets, limits, rounding, reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] CHROMA_OFF = 10'h200;
  localparam logic [9:0] CCIR_LUMA_OFF = 10'h040;
  localparam logic [9:0] ZERO_OFF = 10'h000;
  localparam logic [9:0] FULL_MIN = 10'h000;
  localparam logic [9:0] FULL_MAX = 10'h3FF;
  localparam logic [9:0] CCIR_MIN = 10'h004;
  localparam logic [9:0] CCIR_MAX = 10'h3FB;
  localparam logic signed [15:0] RND_HALF = 16'sh0002;
  localparam logic [PIX_W-1:0] PIX_RST = 30'h00000000;
  localparam logic [1:0] CNT_RST = 2'h0;

  // ----------------------------------------------------------------
  // Matrices, 12 fraction bits, rows = output components,
  // packed {r0c0,r0c1,r0c2,r1c0,...}; rounded toward the high side
  // ----------------------------------------------------------------
  localparam logic [MAT_W-1:0] M_RGB_YUV = {
    15'h0800, 15'h794C, 15'h7EB5,
    15'h04C9, 15'h0965, 15'h01D3,
    15'h7D4C, 15'h7AB5, 15'h0800};
  localparam logic [MAT_W-1:0] M_RGB_CCIR = {
    15'h0702, 15'h7A21, 15'h7EDE,
    15'h0419, 15'h080B, 15'h0190,
    15'h7DA2, 15'h7B5D, 15'h0702};
  localparam logic [MAT_W-1:0] M_YUV_RGB = {
    15'h166F, 15'h1000, 15'h0000,
    15'h7493, 15'h1000, 15'h7A7F,
    15'h0000, 15'h1000, 15'h1C5B};
  localparam logic [MAT_W-1:0] M_CCIR_RGB = {
    15'h199D, 15'h12B0, 15'h0000,
    15'h72F5, 15'h12B0, 15'h79B7,
    15'h0000, 15'h12B0, 15'h205F};
  localparam logic [MAT_W-1:0] M_YUV_CCIR = {
    15'h0E04, 15'h0000, 15'h0000,
    15'h0000, 15'h0DB4, 15'h0000,
    15'h0000, 15'h0000, 15'h0E04};
  localparam logic [MAT_W-1:0] M_CCIR_YUV = {
    15'h1245, 15'h0000, 15'h0000,
    15'h0000, 15'h12B0, 15'h0000,
    15'h0000, 15'h0000, 15'h1245};
  localparam logic [MAT_W-1:0] M_NONE = 135'h0;

endpackage : csc_pkg

// File: src/pixel_skid_buffer.sv
/*
  Small shift FIFO with valid/ready on both sides; head word and both
  handshake outputs come from flip-flops.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pixel_skid_buffer #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[0];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Occupancy and handshake flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_valid <= cnt_nxt != '0;
      in_ready <= cnt_nxt != CW'(DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // Storage: shift on pop, write behind the last kept word
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && (CW'(i) == cnt_r - CW'(pop))) begin
          mem_r[i] <= in_data;
        end else if (pop && i < DEPTH - 1) begin
          mem_r[i] <= mem_r[i+1];
        end
      end
    end
  end

  property p_full_blocks;
    @(posedge clock) disable iff (!nrst)
    (cnt_r == CW'(DEPTH)) |-> !in_ready;
  endproperty
  a_full_blocks: assert property (p_full_blocks)
    else $error("buffer full but still ready");

  property p_word_held;
    @(posedge clock) disable iff (!nrst)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data));
  endproperty
  a_word_held: assert property (p_word_held)
    else $error("stalled output word lost or changed");

endmodule : pixel_skid_buffer

`default_nettype wire

// File: verification/color_space_matrix_converter_test.sv
/*
  Self-checking bench for the colour-space converter: bypass, forward and
  inverse conversions, round trips, clamping and sink stalls.
  Assumes the pixel_sink_model partner and csc_pkg.
*/
`timescale 1ns/1ps
`default_nettype none

module color_space_matrix_converter_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [29:0] in_pixel = 30'h00000000;
  logic [1:0] in_space = 2'h0;
  logic [1:0] dst_space = 2'h0;
  logic out_valid;
  logic out_ready;
  logic [29:0] out_pixel;
  logic [1:0] out_space;
  logic [1:0] mode = 2'h0;
  int mismatches = 0;
  int n_checks = 0;
  int tq[$];

  always #20 clock = ~clock;

  color_space_matrix_converter color_space_matrix_converter_i (
    .clock(clock), .nrst(nrst), .in_valid(in_valid), .in_ready(in_ready),
    .in_pixel(in_pixel), .in_space(in_space), .dst_space(dst_space),
    .out_valid(out_valid), .out_ready(out_ready), .out_pixel(out_pixel),
    .out_space(out_space));

  pixel_sink_model pixel_sink_model_i (
    .clock(clock), .nrst(nrst), .mode(mode), .out_valid(out_valid),
    .out_ready(out_ready), .out_pixel(out_pixel), .out_space(out_space));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  function automatic logic [29:0] px(input logic [9:0] a, b, c);
    px = {a, b, c};
  endfunction : px

  // Snap each component to the expected one when within tol codes
  function automatic logic [31:0] near(input logic [31:0] s, e,
                                       input int tol);
    near = s;
    for (int i = 0; i < 3; i++) begin
      int df;
      df = int'(s[i*10+:10]) - int'(e[i*10+:10]);
      if (!$isunknown(s) && df <= tol && df >= -tol) begin
        near[i*10+:10] = e[i*10+:10];
      end
    end
  endfunction : near

  task automatic check(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Request held until an edge with in_ready high; full 4:4:4 words only
  task automatic send(input logic [29:0] p, input logic [1:0] s, d);
    logic ok;
    in_valid <= 1'b1;
    in_pixel <= p;
    in_space <= s;
    dst_space <= d;
    do begin
      @(negedge clock);
      ok = in_ready;
      @(posedge clock);
    end while (!ok);
    tq.push_back(pixel_sink_model_i.cyc);
  endtask : send

  task automatic idle();
    in_valid <= 1'b0;
    @(posedge clock);
  endtask : idle

  task automatic drain(input int n);
    int k;
    k = 0;
    while (pixel_sink_model_i.got.size() < n && k < 60) begin
      @(posedge clock);
      k++;
    end
    if (pixel_sink_model_i.got.size() < n) begin
      mismatches++;
      $display("[FAIL] %0t drain timed out", $time);
    end
  endtask : drain

  task automatic flush();
    pixel_sink_model_i.got.delete();
    pixel_sink_model_i.got_t.delete();
    tq.delete();
  endtask : flush

  task automatic conv(input logic [29:0] p, input logic [1:0] s, d,
                      output logic [31:0] r);
    flush();
    send(p, s, d);
    idle();
    drain(1);
    r = pixel_sink_model_i.got.size() ? pixel_sink_model_i.got[0] : '1;
  endtask : conv

  task automatic pt(input logic [29:0] p, input logic [1:0] s, d,
                    input logic [29:0] e, input int tol);
    logic [31:0] r;
    conv(p, s, d, r);
    check(near(r, {d, e}, tol), {d, e});
  endtask : pt

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(posedge clock);
    @(negedge clock);
    check({30'h0, in_ready, out_valid}, 32'h00000000);
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    check({31'h0, in_ready}, 32'h00000001);
    @(posedge clock);
    $display("test reset done");
  endtask : t_reset

  // Matching and reserved spaces pass bit exact, back to back, latency 4
  task automatic t_bypass();
    logic [1:0] sp[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    flush();
    for (int i = 0; i < 4; i++) begin
      send(px(10'(10'h3FF - i), 10'h155, 10'(10'h2AA + i)), sp[i], sp[i]);
    end
    send(px(10'h001, 10'h3FE, 10'h123), 2'h0, 2'h3);
    idle();
    drain(5);
    for (int i = 0; i < 5; i++) begin
      check(pixel_sink_model_i.got[i], i < 4 ?
            {sp[i], px(10'(10'h3FF - i), 10'h155, 10'(10'h2AA + i))} :
            {2'h3, px(10'h001, 10'h3FE, 10'h123)});
      check(pixel_sink_model_i.got_t[i] - tq[i], 4);
    end
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_forward();
    pt(px(10'h000, 10'h000, 10'h000), 2'h0, 2'h1,
       px(10'h200, 10'h000, 10'h200), 1);
    pt(px(10'h3FF, 10'h3FF, 10'h3FF), 2'h0, 2'h1,
       px(10'h200, 10'h3FF, 10'h200), 1);
    pt(px(10'h000, 10'h000, 10'h000), 2'h0, 2'h2,
       px(10'h200, 10'h040, 10'h200), 1);
    pt(px(10'h3FF, 10'h3FF, 10'h3FF), 2'h0, 2'h2,
       px(10'h200, 10'h3AC, 10'h200), 1);
    pt(px(10'h200, 10'h3FF, 10'h200), 2'h1, 2'h2,
       px(10'h200, 10'h3AC, 10'h200), 1);
    $display("test forward done");
  endtask : t_forward

  task automatic t_inverse();
    pt(px(10'h200, 10'h040, 10'h200), 2'h2, 2'h0,
       px(10'h000, 10'h000, 10'h000), 1);
    pt(px(10'h200, 10'h3AC, 10'h200), 2'h2, 2'h0,
       px(10'h3FF, 10'h3FF, 10'h3FF), 1);
    pt(px(10'h200, 10'h004, 10'h200), 2'h2, 2'h0,
       px(10'h000, 10'h000, 10'h000), 0);
    pt(px(10'h200, 10'h3FB, 10'h200), 2'h2, 2'h0,
       px(10'h3FF, 10'h3FF, 10'h3FF), 0);
    pt(px(10'h200, 10'h004, 10'h200), 2'h2, 2'h1,
       px(10'h200, 10'h000, 10'h200), 1);
    pt(px(10'h200, 10'h3FB, 10'h200), 2'h2, 2'h1,
       px(10'h200, 10'h3FF, 10'h200), 1);
    $display("test inverse done");
  endtask : t_inverse

  // RGB out and back through YUV and CCIR
  task automatic t_round();
    logic [29:0] c[4] = '{px(10'h3FF, 10'h000, 10'h000),
      px(10'h000, 10'h000, 10'h3FF), px(10'h064, 10'h258, 10'h384),
      px(10'h1FF, 10'h200, 10'h201)};
    logic [31:0] r1;
    logic [31:0] r2;
    for (int i = 0; i < 4; i++) begin
      conv(c[i], 2'h0, 2'h1, r1);
      conv(r1[29:0], 2'h1, 2'h0, r2);
      check(near(r2, {2'h0, c[i]}, 3), {2'h0, c[i]});
      conv(c[i], 2'h0, 2'h2, r1);
      conv(r1[29:0], 2'h2, 2'h0, r2);
      check(near(r2, {2'h0, c[i]}, 4), {2'h0, c[i]});
    end
    $display("test round trip done");
  endtask : t_round

  // Sink refuses, pipeline fills and freezes, nothing lost
  task automatic t_stall();
    flush();
    mode <= 2'h1;
    @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      send(px(10'(10'h010 + i), 10'h020, 10'h030), 2'h2, 2'h2);
    end
    idle();
    repeat (3) @(posedge clock);
    @(negedge clock);
    check({31'h0, in_ready}, 32'h00000000);
    fork
      begin
        send(px(10'h015, 10'h020, 10'h030), 2'h2, 2'h2);
        idle();
      end
      begin
        repeat (4) @(posedge clock);
        mode <= 2'h2;
      end
    join
    drain(6);
    for (int i = 0; i < 6; i++) begin
      check(pixel_sink_model_i.got[i],
            {2'h2, px(10'(10'h010 + i), 10'h020, 10'h030)});
    end
    mode <= 2'h0;
    $display("test stall done");
  endtask : t_stall

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    t_reset();
    t_bypass();
    t_forward();
    t_inverse();
    t_round();
    t_stall();
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    summarize();
  end
endmodule : color_space_matrix_converter_test

`default_nettype wire

// File: verification/pixel_sink_model.sv
/*
  Behavioural sink standing after the converter: drives out_ready in a
  selectable pattern and records every word it takes, with a cycle stamp.
  Assumes the converter's clock and active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pixel_sink_model (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Pattern: 0 always ready, 1 never ready, 2 every other cycle
  input wire logic [1:0] mode,
  // Pixel stream from the converter
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [29:0] out_pixel,
  input wire logic [1:0] out_space
);
  logic [31:0] got[$];
  int got_t[$];
  int cyc;

  initial out_ready = 1'b0;
  initial cyc = 0;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= (mode == 2'h0) || (mode == 2'h2 && !out_ready);
      if (out_valid && out_ready) begin
        got.push_back({out_space, out_pixel});
        got_t.push_back(cyc);
      end
    end
    cyc <= cyc + 1;
  end
endmodule : pixel_sink_model

`default_nettype wire
